// File: hdl/watchpoint_trace_trigger.sv
// Watchpoint hit flags and trace start/stop trigger logic with a Wishbone register slave
`include "wpt_cfg.svh"
`default_nettype none

module watchpoint_trace_trigger (
  input  wire logic                     CORE_CLK,
  input  wire logic                     RST,
  // Wishbone classic slave
  input  wire logic                     WB_CYC_I,
  input  wire logic                     WB_STB_I,
  input  wire logic                     WB_WE_I,
  input  wire logic [`WPT_ADR_W-1:0]    WB_ADR_I,
  input  wire logic [3:0]               WB_SEL_I,
  input  wire wpt_pkg::word_t           WB_DAT_I,
  output var  wpt_pkg::word_t           WB_DAT_O,
  output var  logic                     WB_ACK_O,
  // Core bus access qualifiers, one cycle per access
  input  wire logic                     ACC_VALID,
  input  wire logic                     ACC_FETCH,
  input  wire logic                     ACC_WRITE,
  // Compare results from the comparator value and mask logic
  input  wire logic                     CMP0_ADDR_HIT,
  input  wire logic                     CMP0_DATA_HIT,
  input  wire logic                     CMP1_ADDR_HIT,
  // Trace master control enables
  input  wire logic                     TRACE_BEGIN_ENABLE,
  input  wire logic                     TRACE_HALT_ENABLE,
  // Comparator 0 data compare set-up for the value logic
  output var  logic                     DATA_COMPARE_ENABLE,
  output var  logic [`WPT_SIZE_W-1:0]   DATA_COMPARE_SIZE,
  output var  logic                     LINKED_COMPARATOR_SELECT,
  // Trace buffer triggers and interrupt
  output var  logic                     TRACE_BEGIN_PULSE,
  output var  logic                     TRACE_HALT_PULSE,
  output var  logic                     IRQ
);

  import wpt_pkg::*;

  // Byte lane mask from the Wishbone select lines
  function automatic word_t lane_mask(input logic [3:0] sel);
    word_t m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{sel[i]}};
    end
    return m;
  endfunction : lane_mask

  // True when the access kind is one the action code selects
  // Reserved codes are kept as written but never hit, so a stray code stays harmless
  function automatic logic op_hit(input logic [3:0] fn, input logic fetch,
                                  input logic wr);
    logic r;
    r = 1'b0;
    case (fn)
      FN_FETCH: r = fetch;
      FN_READ:  r = !fetch && !wr;
      FN_WRITE: r = !fetch && wr;
      FN_RDWR:  r = !fetch;
      default:  r = 1'b0;                   // Disabled and reserved codes never hit
    endcase
    return r;
  endfunction : op_hit

  // Register state
  // Everything software can see lives here; reset clears all of it
  logic [3:0]             fn0_reg;
  logic [3:0]             fn0_next;
  logic [3:0]             fn1_reg;
  logic [3:0]             fn1_next;
  logic                   dve_reg;
  logic                   dve_next;
  logic [`WPT_SIZE_W-1:0] size_reg;
  logic [`WPT_SIZE_W-1:0] size_next;
  logic                   link_reg;
  logic                   link_next;
  logic                   kind0_reg;
  logic                   kind0_next;
  logic                   kind1_reg;
  logic                   kind1_next;
  logic                   hit0_reg;
  logic                   hit0_next;
  logic                   hit1_reg;
  logic                   hit1_next;
  logic                   hit0_prev_reg;
  logic                   hit1_prev_reg;
  logic [`WPT_IRQ_W-1:0]  irq_stat_reg;
  logic [`WPT_IRQ_W-1:0]  irq_stat_next;
  logic [`WPT_IRQ_W-1:0]  irq_mask_reg;
  logic [`WPT_IRQ_W-1:0]  irq_mask_next;
  logic                   begin_reg;
  logic                   begin_next;
  logic                   halt_reg;
  logic                   halt_next;
  logic                   ack_reg;
  word_t                  rdata_reg;
  word_t                  rdata_next;

  // Bus request decode; a request is taken at the edge where ack rises
  // Ack is registered, so each request costs one wait state; a strobe still
  // held after ack would be taken again, which the master avoids by dropping it
  wire logic  req_take  = WB_CYC_I && WB_STB_I && !ack_reg;
  wire logic  wr_take   = req_take && WB_WE_I;
  wire logic  rd_take   = req_take && !WB_WE_I;
  wire logic  at_fct0   = WB_ADR_I == `WPT_FCT0_OFF;
  wire logic  at_fct1   = WB_ADR_I == `WPT_FCT1_OFF;
  wire logic  at_tbctrl = WB_ADR_I == `WPT_TBCTRL_OFF;
  wire logic  at_stat   = WB_ADR_I == `WPT_IRQ_STAT_OFF;
  wire logic  at_mask   = WB_ADR_I == `WPT_IRQ_MASK_OFF;
  wire logic  at_devcfg = WB_ADR_I == `WPT_DEVCFG_OFF;
  wire word_t wmask     = lane_mask(WB_SEL_I);

  // Register images as software sees them
  // Fixed and read-only bits are tied here, so reads and merges agree on them
  word_t fct0_img;
  word_t fct1_img;
  word_t tbctrl_img;

  always_comb begin
    fct0_img = '0;
    fct0_img[`WPT_FN_LO +: `WPT_FN_W]     = fn0_reg;
    fct0_img[`WPT_DVE_BIT]                = dve_reg;
    fct0_img[`WPT_SIZE_LO +: `WPT_SIZE_W] = size_reg;
    fct0_img[`WPT_LINK_BIT]               = link_reg;
    fct0_img[`WPT_HIT_BIT]                = hit0_reg;
    // Only action code and flag exist; all else reads zero
    fct1_img = '0;
    fct1_img[`WPT_FN_LO +: `WPT_FN_W]     = fn1_reg;
    fct1_img[`WPT_HIT_BIT]                = hit1_reg;
    // Count field fixed, bits 27 to 2 stay zero
    tbctrl_img = '0;
    tbctrl_img[`WPT_COUNT_LO +: `WPT_COUNT_W] = `WPT_COUNT_VAL;
    tbctrl_img[`WPT_KIND0_BIT]                = kind0_reg;
    tbctrl_img[`WPT_KIND1_BIT]                = kind1_reg;
  end

  // Byte-lane merge of write data into the current images
  // Unselected lanes keep their old value in the images but write zero to the mask; read-only bits are never copied
  // back out of the merge, which is how writes to them are ignored
  wire word_t fct0_wr = (fct0_img & ~wmask) | (WB_DAT_I & wmask);
  wire word_t fct1_wr = (fct1_img & ~wmask) | (WB_DAT_I & wmask);
  wire word_t tbc_wr  = (tbctrl_img & ~wmask) | (WB_DAT_I & wmask);
  wire word_t irq_wr  = WB_DAT_I & wmask;

  // Software-written fields; comparator 1 keeps only its action code
  // Only one offset decodes per cycle, so one branch of the chain is enough
  // Interrupt status is not here: it mixes hardware sets with software clears
  always_comb begin
    fn0_next   = fn0_reg;
    dve_next   = dve_reg;
    size_next  = size_reg;
    link_next  = link_reg;
    fn1_next   = fn1_reg;
    kind0_next = kind0_reg;
    kind1_next = kind1_reg;
    irq_mask_next = irq_mask_reg;
    if (wr_take && at_fct0) begin
      fn0_next  = fct0_wr[`WPT_FN_LO +: `WPT_FN_W];
      dve_next  = fct0_wr[`WPT_DVE_BIT];
      size_next = fct0_wr[`WPT_SIZE_LO +: `WPT_SIZE_W];
      link_next = fct0_wr[`WPT_LINK_BIT];            // One bit: values 0 or 1 only
    end else if (wr_take && at_fct1) begin
      fn1_next  = fct1_wr[`WPT_FN_LO +: `WPT_FN_W];
    end else if (wr_take && at_tbctrl) begin
      kind0_next = tbc_wr[`WPT_KIND0_BIT];
      kind1_next = tbc_wr[`WPT_KIND1_BIT];
    end else if (wr_take && at_mask) begin
      irq_mask_next = irq_wr[`WPT_IRQ_W-1:0];
    end
  end

  // Match events of this cycle
  // Access qualifiers and compare results arrive on this clock and stand one
  // cycle, so they are used directly with no synchronising flops
  wire logic acc0      = ACC_VALID && op_hit(fn0_reg, ACC_FETCH, ACC_WRITE);
  // Comparator 1 address hit comes from its mask logic, so a range when masked
  wire logic link_hit  = link_reg ? CMP1_ADDR_HIT : 1'b1;
  wire logic cmp0_cond = dve_reg ? (CMP0_DATA_HIT && link_hit) : CMP0_ADDR_HIT;
  wire logic ev0       = acc0 && cmp0_cond;
  // Comparator 1 has no data compare; with its code zero it only feeds the link
  // Its address hit therefore serves both its own flag and comparator 0's link
  wire logic ev1       = ACC_VALID && op_hit(fn1_reg, ACC_FETCH, ACC_WRITE) && CMP1_ADDR_HIT;

  // Flags clear on a taken read, but a coincident match keeps them set
  // Set beats clear: a match in the read's cycle would otherwise be lost, since
  // the read returns the old flag and software would never see that match
  assign hit0_next = ev0 || (hit0_reg && !(rd_take && at_fct0));
  assign hit1_next = ev1 || (hit1_reg && !(rd_take && at_fct1));

  // Rising flag seen one cycle late, so the pulse lands the cycle after it sets
  // Edge on the flag rather than on the event: more matches while the flag
  // stands give no further triggers until software reads and clears it
  wire logic rise0 = hit0_reg && !hit0_prev_reg;
  wire logic rise1 = hit1_reg && !hit1_prev_reg;

  // Map each rise to start or stop by its kind bit
  wire logic want_begin = (rise0 && kind0_reg) || (rise1 && kind1_reg);
  wire logic want_halt  = (rise0 && !kind0_reg) || (rise1 && !kind1_reg);
  // Enables gate each trigger; start suppresses a same-cycle stop
  // Enables are sampled once, as the flag first reads high; turning one on
  // later does not replay a trigger that was already dropped
  assign begin_next = want_begin && TRACE_BEGIN_ENABLE;
  assign halt_next  = want_halt && TRACE_HALT_ENABLE && !begin_next;

  // Interrupt status: sticky, write one to clear, a new event wins
  // Status records flag rises, not the flags, so reading a function register
  // leaves the interrupt standing until software clears the status bit
  wire logic [`WPT_IRQ_W-1:0] irq_ev  = {rise1, rise0};
  wire logic [`WPT_IRQ_W-1:0] irq_clr = (wr_take && at_stat) ? irq_wr[`WPT_IRQ_W-1:0]
                                                             : `WPT_IRQ_RST;
  assign irq_stat_next = irq_ev | (irq_stat_reg & ~irq_clr);

  // Read data select; unmapped offsets read zero and still get ack
  // Data is zero outside the ack cycle, so a late sample never sees stale data
  always_comb begin
    rdata_next = '0;
    if (!rd_take) begin
      rdata_next = '0;
    end else if (at_fct0) begin
      rdata_next = fct0_img;
    end else if (at_fct1) begin
      rdata_next = fct1_img;
    end else if (at_tbctrl) begin
      rdata_next = tbctrl_img;
    end else if (at_stat) begin
      rdata_next[`WPT_IRQ_W-1:0] = irq_stat_reg;
    end else if (at_mask) begin
      rdata_next[`WPT_IRQ_W-1:0] = irq_mask_reg;
    end else if (at_devcfg) begin
      rdata_next = `WPT_DEVCFG_VAL;
    end
  end

  // Bus answer: one ack per request, data registered with it
  // Ack rises on the take edge itself, one cycle after the request; no other wait states exist
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ack_reg   <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ack_reg   <= req_take;
      rdata_reg <= rdata_next;
    end
  end

  // Comparator set-up fields
  // Set-up fields drive the value logic directly, so they reset to a disabled unit
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      fn0_reg  <= `WPT_FN_RST;
      fn1_reg  <= `WPT_FN_RST;
      dve_reg  <= 1'b0;
      size_reg <= `WPT_SIZE_RST;
      link_reg <= 1'b0;
    end else begin
      fn0_reg  <= fn0_next;
      fn1_reg  <= fn1_next;
      dve_reg  <= dve_next;
      size_reg <= size_next;
      link_reg <= link_next;
    end
  end

  // Trigger kind and interrupt registers
  // Both kinds reset to stop, so an early match can never start recording
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      kind0_reg    <= 1'b0;
      kind1_reg    <= 1'b0;
      irq_stat_reg <= `WPT_IRQ_RST;
      irq_mask_reg <= `WPT_IRQ_RST;
    end else begin
      kind0_reg    <= kind0_next;
      kind1_reg    <= kind1_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  // Hit flags and their delayed copies
  // The delayed copies only serve edge detection; they reset low, so no false rise
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      hit0_reg      <= 1'b0;
      hit1_reg      <= 1'b0;
      hit0_prev_reg <= 1'b0;
      hit1_prev_reg <= 1'b0;
    end else begin
      hit0_reg      <= hit0_next;
      hit1_reg      <= hit1_next;
      hit0_prev_reg <= hit0_reg;
      hit1_prev_reg <= hit1_reg;
    end
  end

  // Trigger pulses and interrupt line, all from flops
  // IRQ is built from next-state status and mask so the line moves in the same
  // cycle as the status register it reflects
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      begin_reg <= 1'b0;
      halt_reg  <= 1'b0;
      IRQ       <= 1'b0;
    end else begin
      begin_reg <= begin_next;
      halt_reg  <= halt_next;
      IRQ       <= |(irq_stat_next & irq_mask_next);
    end
  end

  // Outputs are the registers themselves
  // No logic sits between these flops and the pins
  assign WB_ACK_O                 = ack_reg;
  assign WB_DAT_O                 = rdata_reg;
  assign TRACE_BEGIN_PULSE        = begin_reg;
  assign TRACE_HALT_PULSE         = halt_reg;
  assign DATA_COMPARE_ENABLE      = dve_reg;
  assign DATA_COMPARE_SIZE        = size_reg;
  assign LINKED_COMPARATOR_SELECT = link_reg;

endmodule : watchpoint_trace_trigger

`default_nettype wire

// File: hdl/wpt_cfg.svh
// Register offsets, field positions, reset values and fixed words of the trigger block
`ifndef WPT_CFG_SVH
`define WPT_CFG_SVH

// Register byte offsets inside the unit window
`define WPT_ADR_W          12
`define WPT_FCT0_OFF       12'h028
`define WPT_FCT1_OFF       12'h038
`define WPT_TBCTRL_OFF     12'h200
`define WPT_IRQ_STAT_OFF   12'h300
`define WPT_IRQ_MASK_OFF   12'h304
`define WPT_DEVCFG_OFF     12'hfc8

// Comparator function register fields
`define WPT_FN_LO          0
`define WPT_FN_W           4
`define WPT_DVE_BIT        8
`define WPT_SIZE_LO        10
`define WPT_SIZE_W         2
`define WPT_LINK_BIT       12
`define WPT_HIT_BIT        24

// Trace trigger control fields
`define WPT_KIND0_BIT      0
`define WPT_KIND1_BIT      1
`define WPT_COUNT_LO       28
`define WPT_COUNT_W        4
`define WPT_COUNT_VAL      4'h2

// Interrupt status and mask layout
`define WPT_IRQ_W          2
`define WPT_IRQ_HIT0_BIT   0
`define WPT_IRQ_HIT1_BIT   1

// Reset and fixed values
`define WPT_FN_RST         4'h0
`define WPT_SIZE_RST       2'h0
`define WPT_IRQ_RST        2'h0
`define WPT_DEVCFG_VAL     32'h0000_0000

`endif

// File: hdl/wpt_pkg.sv
// Types shared by the watchpoint trace trigger block
`default_nettype none

package wpt_pkg;

  // Action select codes of a comparator function register
  typedef enum logic [3:0] {
    FN_OFF   = 4'b0000,
    FN_FETCH = 4'b0100,
    FN_READ  = 4'b0101,
    FN_WRITE = 4'b0110,
    FN_RDWR  = 4'b0111
  } fn_code_t;

  typedef logic [31:0] word_t;

endpackage : wpt_pkg

`default_nettype wire

// File: tb/core_trace_model.sv
// Core access source and trace buffer recorder facing the trigger block
`default_nettype none
module core_trace_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic begin_pulse,
  input  wire logic halt_pulse,
  output wire logic acc_valid,
  output wire logic acc_fetch,
  output wire logic acc_write,
  output wire logic hit0_addr,
  output wire logic hit0_data,
  output wire logic hit1_addr,
  output var  logic recording
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] drv = 6'h0;
  int n_begin = 0;
  int n_halt = 0;
  assign {acc_valid, acc_fetch, acc_write, hit0_addr, hit0_data, hit1_addr} = drv;
  // One access per call; qualifiers flip afterwards so stale hits never pass for live ones
  task automatic access(input logic [4:0] k);
    drv <= {1'b1, k};
    @(posedge clk);
    drv <= {1'b0, ~k};
  endtask : access
  // Recording state; a start beside a stop still starts
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      recording <= 1'b0;
    end else begin
      n_begin <= n_begin + begin_pulse;
      n_halt <= n_halt + halt_pulse;
      if (begin_pulse || halt_pulse) recording <= begin_pulse;
    end
  end
endmodule : core_trace_model
`default_nettype wire

// File: tb/watchpoint_trace_trigger_bench.sv
// Self-checking bench for the watchpoint trace trigger block
`include "wpt_cfg.svh"
`default_nettype none
module watchpoint_trace_trigger_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import wpt_pkg::*;
  localparam logic [11:0] fct0 = `WPT_FCT0_OFF, fct1 = `WPT_FCT1_OFF, tbc = `WPT_TBCTRL_OFF;
  localparam logic [11:0] sts = `WPT_IRQ_STAT_OFF, msk = `WPT_IRQ_MASK_OFF;
  logic CORE_CLK, RST, WB_CYC_I, WB_STB_I, WB_WE_I;
  logic [11:0] WB_ADR_I;
  logic [3:0] WB_SEL_I;
  word_t WB_DAT_I, WB_DAT_O, q;
  logic WB_ACK_O, ACC_VALID, ACC_FETCH, ACC_WRITE, CMP0_ADDR_HIT, CMP0_DATA_HIT, CMP1_ADDR_HIT;
  logic TRACE_BEGIN_ENABLE, TRACE_HALT_ENABLE, TRACE_BEGIN_PULSE, TRACE_HALT_PULSE;
  logic DATA_COMPARE_ENABLE, LINKED_COMPARATOR_SELECT, IRQ, recording;
  logic [1:0] DATA_COMPARE_SIZE;
  int n_mismatch = 0, compares = 0;
  watchpoint_trace_trigger dut (.CORE_CLK(CORE_CLK), .RST(RST), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
    .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .ACC_VALID(ACC_VALID),
    .ACC_FETCH(ACC_FETCH), .ACC_WRITE(ACC_WRITE), .CMP0_ADDR_HIT(CMP0_ADDR_HIT),
    .CMP0_DATA_HIT(CMP0_DATA_HIT), .CMP1_ADDR_HIT(CMP1_ADDR_HIT),
    .TRACE_BEGIN_ENABLE(TRACE_BEGIN_ENABLE), .TRACE_HALT_ENABLE(TRACE_HALT_ENABLE),
    .DATA_COMPARE_ENABLE(DATA_COMPARE_ENABLE), .DATA_COMPARE_SIZE(DATA_COMPARE_SIZE),
    .LINKED_COMPARATOR_SELECT(LINKED_COMPARATOR_SELECT),
    .TRACE_BEGIN_PULSE(TRACE_BEGIN_PULSE), .TRACE_HALT_PULSE(TRACE_HALT_PULSE), .IRQ(IRQ));
  core_trace_model core (.clk(CORE_CLK), .rst(RST), .begin_pulse(TRACE_BEGIN_PULSE),
    .halt_pulse(TRACE_HALT_PULSE), .acc_valid(ACC_VALID), .acc_fetch(ACC_FETCH),
    .acc_write(ACC_WRITE), .hit0_addr(CMP0_ADDR_HIT), .hit0_data(CMP0_DATA_HIT),
    .hit1_addr(CMP1_ADDR_HIT), .recording(recording));
  initial begin
    CORE_CLK = 1'b0;
    forever #5 CORE_CLK = ~CORE_CLK;
  end
  task automatic check(input word_t got, input word_t exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // One classic cycle; the strobe drops for a cycle so the slave never retakes it
  task automatic wb(input logic we, input logic [11:0] a, input word_t d, input logic [3:0] s);
    int n;
    n = 0;
    {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_SEL_I, WB_DAT_I} <= {2'b11, we, a, s, d};
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (WB_ACK_O !== 1'b1 && n < 40);
    q = WB_DAT_O;
    check({31'h0, WB_ACK_O}, 32'h1);
    {WB_CYC_I, WB_STB_I, WB_WE_I} <= 3'b000;
    @(posedge CORE_CLK);
  endtask : wb
  task automatic rd(input logic [11:0] a, input word_t e);
    wb(1'b0, a, 32'h0, 4'hf);
    check(q, e);
  endtask : rd
  task automatic wr(input logic [11:0] a, input word_t d);
    wb(1'b1, a, d, 4'hf);
  endtask : wr
  // Write with chosen byte lanes; unselected lanes keep their bits, except in the interrupt mask, where they write zero
  task automatic wrs(input logic [11:0] a, input word_t d, input logic [3:0] s);
    wb(1'b1, a, d, s);
  endtask : wrs
  task automatic t_regs();
    rd(`WPT_DEVCFG_OFF, 32'h0);
    rd(tbc, 32'h2000_0000);
    wr(tbc, 32'hffff_ffff);
    rd(tbc, 32'h2000_0003);
    wrs(tbc, 32'h0, 4'he);
    rd(tbc, 32'h2000_0003);
    wrs(tbc, 32'h0, 4'h1);
    rd(tbc, 32'h2000_0000);
    wr(fct1, 32'hffff_fff7);
    rd(fct1, 32'h0000_0007);
    wr(fct0, 32'hffff_f9f6);
    rd(fct0, 32'h0000_1906);
    check({28'h0, LINKED_COMPARATOR_SELECT, DATA_COMPARE_ENABLE, DATA_COMPARE_SIZE}, 32'he);
    wr(12'h100, 32'hffff_ffff);
    rd(12'h100, 32'h0);
    $display("t_regs done");
  endtask : t_regs
  // Codes FN_FETCH to FN_RDWR against fetch, read and write; reserved codes never written
  task automatic t_codes();
    logic [1:0] k;
    logic e;
    int b;
    TRACE_BEGIN_ENABLE <= 1'b1;
    TRACE_HALT_ENABLE <= 1'b1;
    wr(tbc, 32'h2);
    for (int i = 4; i < 8; i++) begin
      for (int j = 0; j < 3; j++) begin
        k = (j == 0) ? 2'b10 : (j == 1) ? 2'b00 : 2'b01;
        e = (i == 4) ? k[1] : (i == 5) ? (k == 2'b00) : (i == 6) ? k[0] : !k[1];
        b = core.n_begin;
        wr(fct1, 32'(i));
        core.access({k, 3'b001});
        rd(fct1, {7'h0, e, 20'h0, 4'(i)});
        check(32'(core.n_begin - b), {31'h0, e});
        rd(fct1, 32'(i));
      end
    end
    $display("t_codes done");
  endtask : t_codes
  task automatic t_gate();
    int h;
    h = core.n_halt;
    TRACE_HALT_ENABLE <= 1'b0;
    wr(fct0, 32'h4);
    wr(fct1, 32'h0);
    wr(tbc, 32'h0);
    core.access(5'b10100);
    rd(fct0, 32'h0100_0004);
    check(32'(core.n_halt - h), 32'h0);
    TRACE_HALT_ENABLE <= 1'b1;
    core.access(5'b10100);
    rd(fct0, 32'h0100_0004);
    check(32'(core.n_halt - h), 32'h1);
    wr(tbc, 32'h2);
    wr(fct1, 32'h4);
    core.access(5'b10101);
    rd(fct1, 32'h0100_0004);
    check(32'(core.n_halt - h), 32'h1);
    check({31'h0, recording}, 32'h1);
    rd(fct0, 32'h0100_0004);
    $display("t_gate done");
  endtask : t_gate
  // Linked data compare, comparator 1 action held at zero
  task automatic t_link();
    wr(fct1, 32'h0);
    wr(fct0, 32'h105);
    core.access(5'b00010);
    rd(fct0, 32'h0100_0105);
    wr(fct0, 32'h1105);
    core.access(5'b00010);
    rd(fct0, 32'h0000_1105);
    core.access(5'b00011);
    rd(fct0, 32'h0100_1105);
    wr(fct0, 32'h5);
    core.access(5'b00010);
    rd(fct0, 32'h5);
    $display("t_link done");
  endtask : t_link
  // Match lands on the very edge that takes a read of the same register
  task automatic t_race();
    wr(fct1, 32'h4);
    fork
      rd(fct1, 32'h4);
      core.access(5'b10001);
    join
    rd(fct1, 32'h0100_0004);
    $display("t_race done");
  endtask : t_race
  task automatic t_irq();
    wr(msk, 32'h2);
    wr(sts, 32'h3);
    check({31'h0, IRQ}, 32'h0);
    core.access(5'b10001);
    @(posedge CORE_CLK); // Status bit sets one cycle after the flag
    rd(sts, 32'h2);
    check({31'h0, IRQ}, 32'h1);
    wr(msk, 32'h0);
    check({31'h0, IRQ}, 32'h0);
    wr(msk, 32'h2);
    check({31'h0, IRQ}, 32'h1);
    wr(sts, 32'h2);
    rd(sts, 32'h0);
    check({31'h0, IRQ}, 32'h0);
    $display("t_irq done");
  endtask : t_irq
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  initial begin
    {RST, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_SEL_I, WB_DAT_I} <= {4'b1000, 12'h0, 4'h0, 32'h0};
    {TRACE_BEGIN_ENABLE, TRACE_HALT_ENABLE} <= 2'b00;
    repeat (12) @(posedge CORE_CLK);
    RST <= 1'b0;
    @(posedge CORE_CLK);
    t_regs();
    t_codes();
    t_gate();
    t_link();
    t_race();
    t_irq();
    end_of_test();
  end
  // Whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge CORE_CLK);
    n_mismatch++;
    end_of_test();
  end
endmodule : watchpoint_trace_trigger_bench
`default_nettype wire

// File: tb/wpt_asserts.sv
// Port checker for the watchpoint trace trigger block
`include "wpt_cfg.svh"
`default_nettype none
module wpt_checker (
  input wire logic                  CORE_CLK,
  input wire logic                  RST,
  input wire logic                  WB_CYC_I,
  input wire logic                  WB_STB_I,
  input wire logic                  WB_WE_I,
  input wire logic [`WPT_ADR_W-1:0] WB_ADR_I,
  input wire wpt_pkg::word_t        WB_DAT_O,
  input wire logic                  WB_ACK_O,
  input wire logic                  ACC_VALID,
  input wire logic                  TRACE_BEGIN_ENABLE,
  input wire logic                  TRACE_HALT_ENABLE,
  input wire logic                  TRACE_BEGIN_PULSE,
  input wire logic                  TRACE_HALT_PULSE
);
  timeunit 1ns;
  timeprecision 1ps;
  import wpt_pkg::*;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // A request is new only while ack is low, so a held strobe is not counted twice
  wire take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  wire rd   = take && !WB_WE_I;
  property p_ack; take |=> WB_ACK_O; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_prio; TRACE_BEGIN_PULSE |-> !TRACE_HALT_PULSE; endproperty
  a_prio: assert property (p_prio) else $error("start beside stop");
  property p_ben; TRACE_BEGIN_PULSE |-> $past(TRACE_BEGIN_ENABLE); endproperty
  a_ben: assert property (p_ben) else $error("start not enabled");
  property p_hen; TRACE_HALT_PULSE |-> $past(TRACE_HALT_ENABLE); endproperty
  a_hen: assert property (p_hen) else $error("stop not enabled");
  property p_blat; TRACE_BEGIN_PULSE |-> $past(ACC_VALID, 2); endproperty
  a_blat: assert property (p_blat) else $error("start off time");
  property p_hlat; TRACE_HALT_PULSE |-> $past(ACC_VALID, 2); endproperty
  a_hlat: assert property (p_hlat) else $error("stop off time");
  property p_cfg;
    rd && WB_ADR_I == `WPT_DEVCFG_OFF |=> WB_DAT_O == `WPT_DEVCFG_VAL;
  endproperty
  a_cfg: assert property (p_cfg) else $error("config word not zero");
  property p_ctl;
    rd && WB_ADR_I == `WPT_TBCTRL_OFF |=> WB_DAT_O[31:2] == {`WPT_COUNT_VAL, 26'h0};
  endproperty
  a_ctl: assert property (p_ctl) else $error("control fixed bits wrong");
  property p_fct1;
    rd && WB_ADR_I == `WPT_FCT1_OFF |=> (WB_DAT_O & 32'hfeff_fff0) == 32'h0;
  endproperty
  a_fct1: assert property (p_fct1) else $error("comparator 1 zero bits set");
endmodule : wpt_checker

bind watchpoint_trace_trigger wpt_checker chk (.CORE_CLK(CORE_CLK), .RST(RST),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .ACC_VALID(ACC_VALID),
  .TRACE_BEGIN_ENABLE(TRACE_BEGIN_ENABLE), .TRACE_HALT_ENABLE(TRACE_HALT_ENABLE),
  .TRACE_BEGIN_PULSE(TRACE_BEGIN_PULSE), .TRACE_HALT_PULSE(TRACE_HALT_PULSE));
`default_nettype wire
